// ===== csr_pkg.sv
// Shared constants and carrier types for the channel slot router
package csr_pkg;

  // ==========================================================================
  // Register map (page zero)
  // ==========================================================================
  localparam logic [7:0] CSR_PAGE_ZERO      = 8'h00;
  localparam logic [7:0] CSR_ADDR_CHAN3     = 8'h0d;
  localparam logic [7:0] CSR_ADDR_CHAN4     = 8'h0e;
  localparam logic [7:0] CSR_ADDR_CHAN5     = 8'h0f;
  localparam logic [7:0] CSR_ADDR_CHAN6     = 8'h10;
  localparam int unsigned CSR_NUM_CHANS     = 4;
  localparam int unsigned CSR_FIRST_CHAN    = 3;

  // ==========================================================================
  // Reset values of the channel configuration registers
  // ==========================================================================
  localparam logic [7:0] CSR_RST_CHAN3      = 8'h02;
  localparam logic [7:0] CSR_RST_CHAN4      = 8'h03;
  localparam logic [7:0] CSR_RST_CHAN5      = 8'h04;
  localparam logic [7:0] CSR_RST_CHAN6      = 8'h05;
  localparam logic [7:0] CSR_RDATA_UNMAPPED = 8'h00;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int unsigned CSR_SLOT_LSB      = 0;
  localparam int unsigned CSR_SLOT_W        = 6;
  localparam int unsigned CSR_LINE_BIT      = 6;
  localparam int unsigned CSR_RSVD_BIT      = 7;
  localparam int unsigned CSR_HALF_BIT      = 5;
  localparam int unsigned CSR_HALF_POS_W    = 5;
  localparam logic        CSR_LINE_PRIMARY  = 1'b0;
  localparam logic        CSR_LINE_SECOND   = 1'b1;
  localparam int unsigned CSR_SAMPLE_W      = 32;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic                  line_sel;
    logic [CSR_SLOT_W-1:0] slot_index;
  } csr_chan_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_reg_req_s;

  typedef struct packed {
    logic                  fmt_tdm;
    logic                  right_half;
    logic [CSR_SLOT_W-1:0] slot_num;
  } csr_slot_pos_s;

  typedef struct packed {
    logic                    secondary;
    logic [1:0]              chan;
    logic [CSR_SLOT_W-1:0]   slot_num;
    logic [CSR_SAMPLE_W-1:0] data;
  } csr_out_word_s;

endpackage

// ===== csr_pipe_buf.sv
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ns
module csr_pipe_buf #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  // Filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Draining side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  typedef struct packed {
    logic         out_valid;
    logic [W-1:0] out_data;
    logic         skid_valid;
    logic [W-1:0] skid_data;
  } buf_state_s;

  buf_state_s state_ff;
  buf_state_s nxt_state;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Head register feeds the port directly; skid catches the word that arrives
  // in the cycle the drain stalls, so no word is lost
  always_comb begin
    nxt_state = state_ff;
    if (out_ready_i || !state_ff.out_valid) begin
      if (state_ff.skid_valid) begin
        nxt_state.out_valid  = 1'b1;
        nxt_state.out_data   = state_ff.skid_data;
        nxt_state.skid_valid = 1'b0;
      end else begin
        nxt_state.out_valid = in_valid_i;
        if (in_valid_i) begin
          nxt_state.out_data = in_data_i;
        end
      end
    end else if (in_valid_i && !state_ff.skid_valid) begin
      nxt_state.skid_valid = 1'b1;
      nxt_state.skid_data  = in_data_i;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ready comes from a flop, so it never depends on the drain combinationally
  assign in_ready_o  = !state_ff.skid_valid;
  assign out_valid_o = state_ff.out_valid;
  assign out_data_o  = state_ff.out_data;

endmodule

// ===== csr_channel_slot_router.sv
// Slot and output-line router for serial audio channels 3 to 6
`timescale 1ns/1ns

module csr_channel_slot_router
  import csr_pkg::*;
#(
  parameter int unsigned SAMPLE_W = csr_pkg::CSR_SAMPLE_W
) (
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         reset_i,
  // Register port
  input  wire csr_pkg::csr_reg_req_s        reg_req_i,
  output logic [7:0]                        reg_rdata_o,
  output logic                              reg_rvalid_o,
  // Slot timing and channel samples
  input  wire logic                         slot_valid_i,
  input  wire csr_pkg::csr_slot_pos_s       slot_pos_i,
  input  wire logic [3:0][SAMPLE_W-1:0]     chan_data_i,
  output logic                              slot_ready_o,
  // Routed words toward the serial output lines
  output logic                              out_valid_o,
  output csr_pkg::csr_out_word_s            out_word_o,
  input  wire logic                         out_ready_i
);

  // ==========================================================================
  // Types and state
  // ==========================================================================
  typedef struct packed {
    csr_chan_cfg_s [CSR_NUM_CHANS-1:0] cfg;
    logic [7:0]                        rdata;
    logic                              rvalid;
  } csr_state_s;

  localparam csr_chan_cfg_s [CSR_NUM_CHANS-1:0] CFG_RESET = {
    csr_chan_cfg_s'(CSR_RST_CHAN6[CSR_LINE_BIT:0]),
    csr_chan_cfg_s'(CSR_RST_CHAN5[CSR_LINE_BIT:0]),
    csr_chan_cfg_s'(CSR_RST_CHAN4[CSR_LINE_BIT:0]),
    csr_chan_cfg_s'(CSR_RST_CHAN3[CSR_LINE_BIT:0])
  };

  csr_state_s    state_ff;
  csr_state_s    nxt_state;
  logic          push_valid;
  csr_out_word_s push_word;
  logic          buf_ready;

  // ==========================================================================
  // Decoding functions
  // ==========================================================================
  // Page-zero address to channel index; shared by the write and read paths
  function automatic logic [2:0] addr_to_chan(input logic [7:0] page, input logic [7:0] addr);
    logic [2:0] res;
    res = 3'h4;
    if (page == CSR_PAGE_ZERO) begin
      unique case (addr)
        CSR_ADDR_CHAN3: res = 3'h0;
        CSR_ADDR_CHAN4: res = 3'h1;
        CSR_ADDR_CHAN5: res = 3'h2;
        CSR_ADDR_CHAN6: res = 3'h3;
        default:        res = 3'h4;
      endcase
    end
    return res;
  endfunction

  // Does a channel's slot field match the slot now on the line
  function automatic logic slot_hit(input csr_chan_cfg_s cfg, input csr_slot_pos_s pos);
    logic hit;
    hit = 1'b0;
    if (pos.fmt_tdm) begin
      hit = (cfg.slot_index == pos.slot_num);
    end else begin
      // Top field bit picks the half, low bits give the position in it
      hit = (cfg.slot_index[CSR_HALF_BIT] == pos.right_half) &&
            (cfg.slot_index[CSR_HALF_POS_W-1:0] == pos.slot_num[CSR_HALF_POS_W-1:0]);
    end
    return hit;
  endfunction

  // ==========================================================================
  // Register access and state update
  // ==========================================================================
  always_comb begin
    logic [2:0] wr_chan;
    logic [2:0] rd_chan;
    wr_chan   = addr_to_chan(reg_req_i.page, reg_req_i.addr);
    rd_chan   = addr_to_chan(reg_req_i.page, reg_req_i.addr);
    nxt_state = state_ff;
    nxt_state.rvalid = 1'b0;
    // Bit 7 of the write data is dropped before it reaches any field
    if (reg_req_i.wr && (wr_chan < 3'h4)) begin
      nxt_state.cfg[wr_chan[1:0]] = csr_chan_cfg_s'(reg_req_i.wdata[CSR_LINE_BIT:CSR_SLOT_LSB]);
    end
    // Unmapped reads answer zero rather than holding stale data
    if (reg_req_i.rd) begin
      nxt_state.rvalid = 1'b1;
      if (rd_chan < 3'h4) begin
        nxt_state.rdata = {1'b0, state_ff.cfg[rd_chan[1:0]]};
      end else begin
        nxt_state.rdata = CSR_RDATA_UNMAPPED;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff.cfg    <= CFG_RESET;
      state_ff.rdata  <= '0;
      state_ff.rvalid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_o  = state_ff.rdata;
  assign reg_rvalid_o = state_ff.rvalid;

  // ==========================================================================
  // Slot routing
  // ==========================================================================
  // Lowest channel wins if software maps two channels to one slot; a slot
  // nobody claims is consumed without producing a word
  always_comb begin
    push_valid = 1'b0;
    push_word  = '0;
    for (int i = CSR_NUM_CHANS - 1; i >= 0; i--) begin
      if (slot_valid_i && slot_hit(state_ff.cfg[i], slot_pos_i)) begin
        push_valid          = 1'b1;
        push_word.secondary = state_ff.cfg[i].line_sel;
        push_word.chan      = 2'(i);
        push_word.slot_num  = slot_pos_i.slot_num;
        push_word.data      = CSR_SAMPLE_W'(chan_data_i[i]);
      end
    end
  end

  // ==========================================================================
  // Output buffer
  // ==========================================================================
  // A stalled receiver backs up into slot_ready_o instead of dropping words
  csr_pipe_buf #(
    .W ($bits(csr_out_word_s))
  ) u_out_buf (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_valid),
    .in_data_i   (push_word),
    .in_ready_o  (buf_ready),
    .out_valid_o (out_valid_o),
    .out_data_o  (out_word_o),
    .out_ready_i (out_ready_i)
  );

  assign slot_ready_o = buf_ready;

endmodule

// ===== csr_router_checker.sv
// Port-level checks for the channel slot router
`timescale 1ns/1ns
module csr_router_checker
  import csr_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 32
) (
  // Clock, reset and register port
  input wire logic                     ref_clk_i,
  input wire logic                     reset_i,
  input wire csr_pkg::csr_reg_req_s    reg_req_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     reg_rvalid_o,
  // Slot and word streams
  input wire logic                     slot_valid_i,
  input wire csr_pkg::csr_slot_pos_s   slot_pos_i,
  input wire logic [3:0][SAMPLE_W-1:0] chan_data_i,
  input wire logic                     slot_ready_o,
  input wire logic                     out_valid_o,
  input wire csr_pkg::csr_out_word_s   out_word_o,
  input wire logic                     out_ready_i
);
  // ====
  // Helper: samples of the cycle a slot was taken
  logic [3:0][SAMPLE_W-1:0] data_ff;
  logic                     take;
  assign take = slot_valid_i && slot_ready_o && !out_valid_o;
  always_ff @(posedge ref_clk_i) begin
    data_ff <= chan_data_i;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // ====
  a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_req_i.rd)) else $error("stray read valid");
  a_rsvd_zero: assert property (reg_rvalid_o |-> !reg_rdata_o[7]) else $error("bit 7 read as one");
  a_unmapped_zero: assert property (reg_req_i.rd && reg_req_i.page != 8'h00 |=> reg_rdata_o == 8'h00)
    else $error("other page read not zero");
  a_word_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_word_o))
    else $error("word dropped under stall");
  a_tdm_slot: assert property (take && slot_pos_i.fmt_tdm |=> !out_valid_o ||
    out_word_o.slot_num == $past(slot_pos_i.slot_num)) else $error("slot number wrong");
  a_word_data: assert property (take |=> !out_valid_o || out_word_o.data == data_ff[out_word_o.chan])
    else $error("sample data wrong");
  a_refuse_full: assert property (!slot_ready_o |-> out_valid_o) else $error("refused while empty");
  a_reset_idle: assert property (@(posedge ref_clk_i) disable iff (1'b0) reset_i |=>
    !out_valid_o && slot_ready_o && !reg_rvalid_o) else $error("not idle after reset");
endmodule

// ===== csr_host_sink.sv
// Host serial port model that collects routed words
`timescale 1ns/1ns
module csr_host_sink
  import csr_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   stall_i,
  input  wire logic                   valid_i,
  input  wire csr_pkg::csr_out_word_s word_i,
  output logic                        ready_o
);
  csr_out_word_s got[$];
  initial ready_o = 1'b0;
  // Ready is registered, so a stall only bites one cycle later
  always @(posedge ref_clk_i) begin
    if (valid_i && ready_o && !reset_i) got.push_back(word_i);
    ready_o <= !stall_i && !reset_i;
  end
endmodule

// ===== csr_channel_slot_router_bench.sv
// Self-checking bench for the channel slot router
`timescale 1ns/1ns
module csr_channel_slot_router_bench;
  import csr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sv = 1'b0, stall = 1'b0, rvalid, sready, ovalid, ordy;
  logic [7:0] rdata;
  logic [3:0][31:0] cdata = '0;
  csr_reg_req_s req = '0;
  csr_slot_pos_s pos = '0;
  csr_out_word_s word;
  int err_count = 0, n_compared = 0, cycles = 0;
  always #5 clk = ~clk;
  csr_channel_slot_router csr_channel_slot_router_i (.ref_clk_i(clk), .reset_i(rst), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .slot_valid_i(sv), .slot_pos_i(pos), .chan_data_i(cdata),
    .slot_ready_o(sready), .out_valid_o(ovalid), .out_word_o(word), .out_ready_i(ordy));
  csr_host_sink sink_i (.ref_clk_i(clk), .reset_i(rst), .stall_i(stall), .valid_i(ovalid), .word_i(word),
    .ready_o(ordy));
  // ====
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register strobe; reads are judged on the answer cycle
  task automatic reg_op(input logic wr, input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] wd,
    input logic [7:0] ex);
    @(posedge clk) req <= '{wr, !wr, pg, ad, wd};
    @(posedge clk) req <= '0;
    #1 if (!wr) chk(64'({rvalid, rdata}), 64'({1'b1, ex}));
  endtask
  // Slot held until taken; samples tagged by channel and slot
  task automatic send(input logic tdm, input logic rh, input logic [5:0] n);
    logic r;
    @(posedge clk) sv <= 1'b1;
    pos <= '{tdm, rh, n};
    cdata <= {32'h4444_4444 + 32'(n), 32'h3333_3333 + 32'(n), 32'h2222_2222 + 32'(n), 32'h1111_1111 + 32'(n)};
    do begin
      #1 r = sready;
      @(posedge clk);
    end while (!r);
    sv <= 1'b0;
  endtask
  task automatic expect_word(input logic [1:0] ch, input logic sec, input logic [5:0] n, input logic cs);
    csr_out_word_s w;
    repeat (20) if (sink_i.got.size() == 0) @(posedge clk);
    w = (sink_i.got.size() != 0) ? sink_i.got.pop_front() : '0;
    if (!cs) w.slot_num = n;
    chk(64'(w), 64'({sec, ch, n, 32'(32'h1111_1111 * (ch + 1) + n)}));
  endtask
  task automatic expect_none;
    repeat (4) @(posedge clk);
    chk(64'(sink_i.got.size()), 64'h0);
  endtask
  // ====
  task automatic t_regs;
    for (int i = 0; i < 4; i++) reg_op(0, 8'h00, 8'(8'h0d + i), 8'h00, 8'(8'h02 + i));
    reg_op(0, 8'h00, 8'h11, 8'h00, 8'h00);
    reg_op(0, 8'h01, 8'h0e, 8'h00, 8'h00);
    reg_op(1, 8'h00, 8'h0e, 8'hff, 8'h00);
    reg_op(0, 8'h00, 8'h0e, 8'h00, 8'h7f);
    reg_op(1, 8'h01, 8'h0e, 8'h12, 8'h00);
    reg_op(0, 8'h00, 8'h0e, 8'h00, 8'h7f);
  endtask
  task automatic t_tdm;
    reg_op(1, 8'h00, 8'h0d, 8'h7f, 8'h00);
    reg_op(1, 8'h00, 8'h0e, 8'h80, 8'h00);
    send(1, 0, 63); expect_word(0, 1, 63, 1);
    send(1, 0, 0); expect_word(1, 0, 0, 1);
    send(1, 0, 4); expect_word(2, 0, 4, 1);
    send(1, 0, 40); expect_none();
  endtask
  task automatic t_half;
    reg_op(1, 8'h00, 8'h0f, 8'h21, 8'h00);
    reg_op(1, 8'h00, 8'h10, 8'h1f, 8'h00);
    send(0, 1, 1); expect_word(2, 0, 1, 0);
    send(0, 0, 31); expect_word(3, 0, 31, 0);
    send(0, 1, 31); expect_word(0, 1, 31, 0);
    send(0, 0, 0); expect_word(1, 0, 0, 0);
    send(0, 0, 1); expect_none();
  endtask
  // Receiver stalls so the second word lands in the skid entry
  task automatic t_stall;
    @(posedge clk) stall <= 1'b1;
    @(posedge clk);
    send(1, 0, 0);
    send(1, 0, 63);
    #1 chk(64'(sready), 64'h0);
    @(posedge clk) stall <= 1'b0;
    send(1, 0, 31);
    expect_word(1, 0, 0, 1);
    expect_word(0, 1, 63, 1);
    expect_word(3, 0, 31, 1);
  endtask
  // ====
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tdm();
    t_half();
    t_stall();
    stop_test();
  end
endmodule
bind csr_channel_slot_router csr_router_checker #(.SAMPLE_W(SAMPLE_W)) csr_router_checker_i (.*);
